/* srg_pkg.sv */
/*
 package for the suspend/resume command gate: opcodes, timing, carriers.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package srg_pkg;
   // ------------------------------------------------------------
   // opcodes (first byte of each command)
   // ------------------------------------------------------------
   localparam logic [7:0] OP_SUSPEND = 8'hb0;
   localparam logic [7:0] OP_RESUME = 8'hd0;
   localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
   localparam logic [7:0] OP_PROT_SEQ = 8'h3d;
   localparam logic [7:0] OP_SECLOCK_SEQ = 8'h3d;
   localparam logic [7:0] OP_PROG_SECURITY = 8'h9b;
   localparam logic [7:0] OP_RD_PROT = 8'h32;
   localparam logic [7:0] OP_RD_LOCK = 8'h35;
   localparam logic [7:0] OP_RD_SECURITY = 8'h77;
   localparam logic [7:0] OP_MM_TO_B1 = 8'h53;
   localparam logic [7:0] OP_MM_TO_B2 = 8'h55;
   localparam logic [7:0] OP_CMP_B1 = 8'h60;
   localparam logic [7:0] OP_CMP_B2 = 8'h61;
   localparam logic [7:0] OP_DEEP_PD = 8'hb9;
   localparam logic [7:0] OP_RES_DEEP_PD = 8'hab;
   localparam logic [7:0] OP_ULTRA_PD = 8'h79;
   localparam logic [7:0] OP_RD_CONFIG = 8'h3f;
   localparam logic [7:0] OP_RD_STATUS = 8'hd7;
   localparam logic [7:0] OP_RD_ID = 8'h9f;
   localparam logic [7:0] OP_SW_RESET = 8'hf0;
   localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLOCK_NS = 50;
   localparam int RESUME_LATENCY_NS = 1000;
   localparam int RESUME_CYCLES = RESUME_LATENCY_NS / CLOCK_NS;
   localparam logic [7:0] RESUME_COUNT = 8'(RESUME_CYCLES);
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic buf_one_prog_suspended;
      logic buf_two_prog_suspended;
      logic erase_suspended_flag;
   } srg_flags_type;
   typedef struct packed {
      logic [7:0] opcode;
      logic accepted;
   } srg_cmd_type;
endpackage
`default_nettype wire

/* srg_gate.sv */
/*
 suspend/resume command gate: captures the command opcode on the serial
 clock, hands it across to the core clock after the first byte, and at chip-select release
 decides acceptance, suspend and resume.
 assumes: spi mode 0 (sample on rising sclk), msb first, the core reports
 operation-in-progress and its kind, and sclk stands still outside frames.
*/
// Function
// - refuse chip erase, protection, lockdown and security programming while suspended
// - accept protection, lockdown and security register reads in any suspend
// - refuse page-to-buffer-one transfer only under buffer-one program suspend
// - refuse page-to-buffer-two transfer only under buffer-two program suspend
// - accept both buffer compares in every suspend state
// - refuse deep power-down entry, exit and ultra-deep entry while suspended
// - accept config, status, identity reads and resets in every suspend state
// - resume is opcode d0 alone; later bytes ignored
// - after resume frame ends, restart suspended operation within resume latency
// - resume clears matching suspend flag and ready reports busy
// - with both suspended, resume restarts program first, erase on next resume
// - suspend commands ignored while a resume is taking effect
// - suspend is opcode b0 alone, taking effect at chip-select release
// - suspend sets matching flag and ready reports ready
// - erase and one program suspend flag may be set together
// - reads of a suspended sector return undefined data
`timescale 1ns/100ps
`default_nettype none
module srg_gate (
   input wire logic clock,
   input wire logic reset,
   input wire logic spi_clock,
   input wire logic chip_select_n,
   input wire logic serial_in,
   input wire logic op_running,
   input wire logic op_is_erase,
   input wire logic op_uses_buf_two,
   input wire logic op_done,
   output logic ready,
   output srg_pkg::srg_flags_type flags,
   output srg_pkg::srg_cmd_type command,
   output logic command_strobe,
   output logic resume_start,
   output logic suspend_start
);
   // ------------------------------------------------------------
   // link domain: opcode shift register, no reset needed on sclk
   // ------------------------------------------------------------
   logic [7:0] shift;
   logic [2:0] bit_count;
   logic [7:0] frame_opcode;
   logic [7:0] next_shift;
   logic [2:0] next_bit_count;
   logic [7:0] next_frame_opcode;
   logic first_byte;
   logic next_first_byte;

   always_comb begin
      next_shift = {shift[6:0], serial_in};
      next_bit_count = bit_count + 3'h1;
      next_frame_opcode = frame_opcode;
      next_first_byte = first_byte;
      // only the first byte is kept; later bytes are ignored
      if (first_byte && bit_count == srg_pkg::BIT_COUNT_LAST) begin
         next_frame_opcode = next_shift;
         next_first_byte = 1'b0;
      end
   end

   // byte position restarts on chip-select release, so frames need no sclk after;
   // limitation: one chip-select rise must come before the first frame after power-up
   always_ff @(posedge spi_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_count <= 3'h0;
         first_byte <= 1'b1;
      end else begin
         bit_count <= next_bit_count;
         first_byte <= next_first_byte;
      end
   end

   always_ff @(posedge spi_clock) begin
      shift <= next_shift;
      frame_opcode <= next_frame_opcode;
   end

   // ------------------------------------------------------------
   // crossing: cs level and first-byte level through two flops each
   // ------------------------------------------------------------
   logic [1:0] cs_sync;
   logic [1:0] byte_sync;
   logic cs_seen;
   logic byte_seen;
   logic byte_landed;
   logic byte_pending;
   logic [7:0] held_opcode;
   logic next_byte_pending;
   logic [7:0] next_held_opcode;
   logic frame_end;

   assign frame_end = cs_sync[1] && !cs_seen;
   // a level cleared by cs needs no reset on sclk, unlike a toggle
   assign byte_landed = byte_seen && !byte_sync[1];

   always_comb begin
      next_byte_pending = byte_pending;
      next_held_opcode = held_opcode;
      // opcode is stable on sclk side: frame_opcode holds after first byte until next frame
      if (byte_landed) begin
         next_byte_pending = 1'b1;
         next_held_opcode = frame_opcode;
      end
      if (frame_end) begin
         next_byte_pending = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      cs_sync <= {cs_sync[0], chip_select_n};
      byte_sync <= {byte_sync[0], first_byte};
      if (reset) begin
         cs_seen <= 1'b1;
         byte_seen <= 1'b1;
         byte_pending <= 1'b0;
         held_opcode <= 8'h00;
      end else begin
         cs_seen <= cs_sync[1];
         byte_seen <= byte_sync[1];
         byte_pending <= next_byte_pending;
         held_opcode <= next_held_opcode;
      end
   end

   // ------------------------------------------------------------
   // acceptance decision
   // ------------------------------------------------------------
   logic any_suspended;
   logic allowed;

   assign any_suspended = flags.buf_one_prog_suspended || flags.buf_two_prog_suspended ||
      flags.erase_suspended_flag;

   always_comb begin
      allowed = 1'b1;
      if (any_suspended) begin
         unique case (held_opcode)
            srg_pkg::OP_CHIP_ERASE, srg_pkg::OP_PROT_SEQ,
            srg_pkg::OP_PROG_SECURITY: allowed = 1'b0;
            srg_pkg::OP_RD_PROT, srg_pkg::OP_RD_LOCK,
            srg_pkg::OP_RD_SECURITY: allowed = 1'b1;
            srg_pkg::OP_MM_TO_B1: allowed = !flags.buf_one_prog_suspended;
            srg_pkg::OP_MM_TO_B2: allowed = !flags.buf_two_prog_suspended;
            srg_pkg::OP_CMP_B1, srg_pkg::OP_CMP_B2: allowed = 1'b1;
            srg_pkg::OP_DEEP_PD, srg_pkg::OP_RES_DEEP_PD,
            srg_pkg::OP_ULTRA_PD: allowed = 1'b0;
            srg_pkg::OP_RD_CONFIG, srg_pkg::OP_RD_STATUS, srg_pkg::OP_RD_ID,
            srg_pkg::OP_SW_RESET: allowed = 1'b1;
            default: allowed = 1'b1; // reads pass; suspended-sector data is undefined
         endcase
      end
   end

   // ------------------------------------------------------------
   // suspend / resume state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RESUMING = 3'b010,
      ST_RUNNING = 3'b100
   } srg_state_type;

   srg_state_type state;
   srg_state_type next_state;
   logic [7:0] count;
   logic [7:0] next_count;
   srg_pkg::srg_flags_type next_flags;
   logic prog_active;
   logic next_prog_active;
   logic erase_active;
   logic next_erase_active;
   srg_pkg::srg_cmd_type next_command;
   logic next_command_strobe;
   logic next_resume_start;
   logic next_suspend_start;
   logic is_suspend;
   logic is_resume;

   assign is_suspend = frame_end && byte_pending && held_opcode == srg_pkg::OP_SUSPEND;
   assign is_resume = frame_end && byte_pending && held_opcode == srg_pkg::OP_RESUME;

   always_comb begin
      next_state = state;
      next_count = count;
      next_flags = flags;
      next_prog_active = prog_active;
      next_erase_active = erase_active;
      next_command = command;
      next_command_strobe = 1'b0;
      next_resume_start = 1'b0;
      next_suspend_start = 1'b0;
      if (op_running && !prog_active && !erase_active && state == ST_IDLE) begin
         next_prog_active = !op_is_erase;
         next_erase_active = op_is_erase;
         next_state = ST_RUNNING;
      end
      unique case (state)
         ST_IDLE: begin
         end
         ST_RESUMING: begin
            // suspends land here and are dropped
            if (count == 8'h00) begin
               next_state = ST_RUNNING;
            end else begin
               next_count = count - 8'h01;
            end
         end
         ST_RUNNING: begin
            if (op_done) begin
               next_prog_active = 1'b0;
               next_erase_active = 1'b0;
               next_state = ST_IDLE;
            end else if (is_suspend) begin
               // suspend a program or an erase
               next_suspend_start = 1'b1;
               next_state = ST_IDLE;
               if (prog_active) begin
                  next_prog_active = 1'b0;
                  next_flags.buf_one_prog_suspended = !op_uses_buf_two;
                  next_flags.buf_two_prog_suspended = op_uses_buf_two;
               end else begin
                  next_erase_active = 1'b0;
                  next_flags.erase_suspended_flag = 1'b1;
               end
            end
         end
      endcase
      if (state == ST_IDLE && is_resume && any_suspended) begin
         // program resumes before erase
         next_resume_start = 1'b1;
         next_state = ST_RESUMING;
         next_count = srg_pkg::RESUME_COUNT;
         if (flags.buf_one_prog_suspended || flags.buf_two_prog_suspended) begin
            next_flags.buf_one_prog_suspended = 1'b0;
            next_flags.buf_two_prog_suspended = 1'b0;
            next_prog_active = 1'b1;
         end else begin
            next_flags.erase_suspended_flag = 1'b0;
            next_erase_active = 1'b1;
         end
      end
      // refused commands never reach the core
      if (frame_end && byte_pending && !is_suspend && !is_resume && allowed) begin
         next_command.opcode = held_opcode;
         next_command.accepted = 1'b1;
         next_command_strobe = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= ST_IDLE;
         count <= 8'h00;
         flags <= '0;
         prog_active <= 1'b0;
         erase_active <= 1'b0;
         command <= '0;
         command_strobe <= 1'b0;
         resume_start <= 1'b0;
         suspend_start <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         flags <= next_flags;
         prog_active <= next_prog_active;
         erase_active <= next_erase_active;
         command <= next_command;
         command_strobe <= next_command_strobe;
         resume_start <= next_resume_start;
         suspend_start <= next_suspend_start;
      end
   end

   // busy while resuming or running
   assign ready = (state == ST_IDLE);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_RESUME_CLEARS: assert property (@(posedge clock) disable iff (reset)
      resume_start |-> !ready && flags != $past(flags) && (flags & $past(flags)) == flags)
      else $error("resume left state wrong");
   AST_RESUME_BOUND: assert property (@(posedge clock) disable iff (reset)
      resume_start |-> ##[1:30] (state == ST_RUNNING))
      else $error("resume not completed in time");
   AST_PROG_FIRST: assert property (@(posedge clock) disable iff (reset)
      (is_resume && state == ST_IDLE && flags.erase_suspended_flag &&
      flags.buf_one_prog_suspended) |=> flags.erase_suspended_flag)
      else $error("erase resumed before program");
   AST_NO_SUSP_RESUMING: assert property (@(posedge clock) disable iff (reset)
      (state == ST_RESUMING) |=> !suspend_start)
      else $error("suspend taken while resuming");
   AST_SUSPEND_READY: assert property (@(posedge clock) disable iff (reset)
      suspend_start |-> ready && (flags != '0))
      else $error("suspend did not set flag");
   AST_REFUSE_CHIP_ERASE: assert property (@(posedge clock) disable iff (reset)
      (frame_end && byte_pending && any_suspended && held_opcode == srg_pkg::OP_CHIP_ERASE)
      |=> !command_strobe)
      else $error("chip erase passed during suspend");
   AST_REFUSE_PD: assert property (@(posedge clock) disable iff (reset)
      (frame_end && byte_pending && any_suspended && held_opcode == srg_pkg::OP_DEEP_PD)
      |=> !command_strobe)
      else $error("power-down passed during suspend");
   AST_ACCEPT_STATUS: assert property (@(posedge clock) disable iff (reset)
      (frame_end && byte_pending && held_opcode == srg_pkg::OP_RD_STATUS)
      |=> command_strobe && command.opcode == srg_pkg::OP_RD_STATUS)
      else $error("status read refused");
   AST_B1_TRANSFER: assert property (@(posedge clock) disable iff (reset)
      (frame_end && byte_pending && held_opcode == srg_pkg::OP_MM_TO_B1 &&
      flags.buf_one_prog_suspended) |=> !command_strobe)
      else $error("buffer one transfer passed");
   COV_SUSPEND: cover property (@(posedge clock) disable iff (reset) suspend_start);
   COV_RESUME: cover property (@(posedge clock) disable iff (reset) resume_start);
   COV_BOTH: cover property (@(posedge clock) disable iff (reset)
      flags.erase_suspended_flag && flags.buf_two_prog_suspended);
endmodule
`default_nettype wire

/* srg_host.sv */
/*
 spi host model for the suspend/resume command gate: one frame per call.
 assumes the gate samples serial_in on rising spi_clock, msb first.
*/
`timescale 1ns/100ps
`default_nettype none
module srg_host (
   output logic spi_clock,
   output logic chip_select_n,
   output logic serial_in
);
   // one select pulse at start-up clears the gate's link-side counter, which has no reset
   initial begin
      spi_clock = 1'b0;
      chip_select_n = 1'b0;
      serial_in = 1'b1;
      #5 chip_select_n = 1'b1;
   end
   // ------------------------------------------------------------
   // frame: opcode, then tail bytes the gate must ignore
   // ------------------------------------------------------------
   // clock stands still outside frames; data idles at the inverse of its last bit
   task automatic send(input logic [7:0] op, input logic [7:0] tail, input int nbytes);
      logic [7:0] b;
      #13;
      chip_select_n = 1'b0;
      for (int i = 0; i < nbytes; i++) begin
         b = (i == 0) ? op : tail;
         for (int k = 7; k >= 0; k--) begin
            serial_in = b[k];
            #40 spi_clock = 1'b1;
            #40 spi_clock = 1'b0;
         end
      end
      #40 chip_select_n = 1'b1;
      serial_in = ~serial_in;
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
/*
 self-checking bench for the suspend/resume command gate.
 assumes srg_pkg, srg_gate and srg_host are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clock, reset, op_running, op_is_erase, op_uses_buf_two, op_done;
   wire logic spi_clock, chip_select_n, serial_in;
   logic ready, command_strobe, resume_start, suspend_start;
   srg_pkg::srg_flags_type flags;
   srg_pkg::srg_cmd_type command;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int m_flags = 0;
   logic [7:0] lfsr = 8'h4a;
   logic seen_cmd, seen_res, seen_sus;
   logic [7:0] ops [17] = '{
      srg_pkg::OP_CHIP_ERASE, srg_pkg::OP_PROT_SEQ, srg_pkg::OP_PROG_SECURITY,
      srg_pkg::OP_RD_PROT, srg_pkg::OP_RD_LOCK, srg_pkg::OP_RD_SECURITY,
      srg_pkg::OP_MM_TO_B1, srg_pkg::OP_MM_TO_B2, srg_pkg::OP_CMP_B1, srg_pkg::OP_CMP_B2,
      srg_pkg::OP_DEEP_PD, srg_pkg::OP_RES_DEEP_PD, srg_pkg::OP_ULTRA_PD,
      srg_pkg::OP_RD_CONFIG, srg_pkg::OP_RD_STATUS, srg_pkg::OP_RD_ID, srg_pkg::OP_SW_RESET};

   srg_gate u_dut (.clock(clock), .reset(reset), .spi_clock(spi_clock),
      .chip_select_n(chip_select_n), .serial_in(serial_in), .op_running(op_running),
      .op_is_erase(op_is_erase), .op_uses_buf_two(op_uses_buf_two), .op_done(op_done),
      .ready(ready), .flags(flags), .command(command), .command_strobe(command_strobe),
      .resume_start(resume_start), .suspend_start(suspend_start));
   srg_host u_host (.spi_clock(spi_clock), .chip_select_n(chip_select_n),
      .serial_in(serial_in));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ------------------------------------------------------------
   // reference model and helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // model flags: bit2 buffer-one program, bit1 buffer-two program, bit0 erase
   function automatic logic accept(input logic [7:0] op, input int f);
      if (f == 0)
         return 1'b1;
      case (op)
         srg_pkg::OP_MM_TO_B1: return (f & 4) == 0;
         srg_pkg::OP_MM_TO_B2: return (f & 2) == 0;
         srg_pkg::OP_CHIP_ERASE, srg_pkg::OP_PROT_SEQ: return 1'b0;
         srg_pkg::OP_PROG_SECURITY: return 1'b0;
         srg_pkg::OP_DEEP_PD, srg_pkg::OP_RES_DEEP_PD, srg_pkg::OP_ULTRA_PD: return 1'b0;
         default: return 1'b1;
      endcase
   endfunction
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one frame, then watch the core side until a strobe or 8 cycles
   task automatic frame(input logic [7:0] op, input logic rnd);
      int n;
      int c;
      lfsr = lfsr_next(lfsr);
      n = rnd ? 1 + int'(lfsr[1:0]) : 1;
      u_host.send(op, lfsr_next(lfsr), n);
      c = 0;
      seen_cmd = 1'b0;
      seen_res = 1'b0;
      seen_sus = 1'b0;
      while (c < 8 && !(seen_cmd || seen_res || seen_sus)) begin
         @(posedge clock);
         #1;
         seen_cmd = command_strobe === 1'b1;
         seen_res = resume_start === 1'b1;
         seen_sus = suspend_start === 1'b1;
         c++;
      end
   endtask
   task automatic gate_all();
      logic acc;
      foreach (ops[i]) begin
         frame(ops[i], 1'b1);
         acc = accept(ops[i], m_flags);
         check("command_strobe", 9'(acc), 9'(seen_cmd));
         if (acc)
            check("command", {ops[i], 1'b1}, command);
         check("flags kept", 9'(m_flags), 9'(flags));
      end
   endtask
   task automatic start_op(input logic erase, input logic two);
      @(posedge clock);
      op_running <= 1'b1;
      op_is_erase <= erase;
      op_uses_buf_two <= two;
      repeat (4) @(posedge clock);
      #1;
      check("ready running", 9'h000, 9'(ready));
   endtask
   task automatic suspend(input int f);
      // the core stops once suspended; its busy level must be low by then or idle restarts it
      @(posedge clock);
      op_running <= 1'b0;
      frame(srg_pkg::OP_SUSPEND, 1'b1);
      check("suspend_start", 9'h001, 9'(seen_sus));
      m_flags |= f;
      check("flags suspend", 9'(m_flags), 9'(flags));
      check("ready suspend", 9'h001, 9'(ready));
   endtask
   task automatic resume(input int f);
      frame(srg_pkg::OP_RESUME, 1'b1);
      check("resume_start", 9'h001, 9'(seen_res));
      m_flags &= ~f;
      check("flags resume", 9'(m_flags), 9'(flags));
      check("ready resume", 9'h000, 9'(ready));
   endtask
   task automatic finish_op();
      @(posedge clock);
      op_running <= 1'b1;
      repeat (25) @(posedge clock);
      op_done <= 1'b1;
      op_running <= 1'b0;
      @(posedge clock);
      op_done <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check("ready done", 9'h001, 9'(ready));
      check("flags done", 9'(m_flags), 9'(flags));
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      reset = 1'b1;
      op_running = 1'b0;
      op_is_erase = 1'b0;
      op_uses_buf_two = 1'b0;
      op_done = 1'b0;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check("ready idle", 9'h001, 9'(ready));
      gate_all();
      start_op(1'b0, 1'b0);
      suspend(4);
      gate_all();
      resume(4);
      // a suspend landing while the resume is still taking effect
      frame(srg_pkg::OP_SUSPEND, 1'b0);
      check("suspend ignored", 9'h000, 9'(seen_sus));
      finish_op();
      start_op(1'b0, 1'b1);
      suspend(2);
      gate_all();
      resume(2);
      finish_op();
      start_op(1'b1, 1'b0);
      suspend(1);
      gate_all();
      start_op(1'b0, 1'b0);
      suspend(4);
      gate_all();
      resume(4);
      finish_op();
      resume(1);
      finish_op();
      results();
   end
endmodule
`default_nettype wire
